// ==== logic/crt_timer.sv ====
// Capture/reload timer with APB register access
//
// Functional notes
// - 16-bit counter, timer or event source
// - Timer counts once per twelve-clock machine cycle
// - Run, baud, capture, reload mode select
// - Count pin sampled once per cycle, falling
// - New count appears at next update phase
// - Capture mode without trigger: overflow flag
// - Trigger edge captures count, sets external flag
// - Both flags interrupt in capture, up-only
// - Up/down enable clears on reset
// - Up-only reload: overflow flag, reload capture
// - Up-only trigger edge reloads, sets external flag
// - Up/down, trigger high: count up, reload
// - Up/down, trigger low: down, reload all ones
// - Up/down toggles external flag, no interrupt
// - Timer request is OR of flags, external flag only outside up/down
// - Mode register: up/down bit0, output bit1
// - Baud mode: half rate, reload, no flag
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module crt_timer #(
  parameter int CNT_W = crt_pkg::CNT_W_DEF
) (
  // Clock, reset, enable
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  ce,
  // APB slave
  input  wire crt_pkg::crt_apb_req_t apb_req,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // External pins
  input  wire logic                  count_pin,
  input  wire logic                  trigger_pin,
  // Outputs
  output logic                       clock_out,
  output logic                       timer_irq,
  output logic                       irq
);

  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
    $error("CNT_W must lie between 2 and 32");
  end

  localparam logic [CNT_W-1:0] ALL_ONES = '1;

  typedef struct packed {
    crt_pkg::crt_ctrl_t ctrl;
    crt_pkg::crt_mode_t mode;
    logic [CNT_W-1:0]   cnt;
    logic [CNT_W-1:0]   cap;
    logic [3:0]         phase;
    logic               pend_cnt;
    logic               pend_trig;
    logic [1:0]         irq_status;
    logic [1:0]         irq_mask;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic               clock_out;
    logic               timer_irq;
    logic               irq;
  } crt_state_t;

  crt_state_t s_r;
  crt_state_t s_nxt;

  logic sample_tick;
  logic cnt_fall;
  logic trig_fall;
  logic trig_level;

  function automatic logic crt_mapped(input logic [7:0] a);
    crt_mapped = (a == crt_pkg::OFS_CTRL) || (a == crt_pkg::OFS_MODE) ||
                 (a == crt_pkg::OFS_COUNT) || (a == crt_pkg::OFS_CAPT) ||
                 (a == crt_pkg::OFS_STATUS) || (a == crt_pkg::OFS_MASK);
  endfunction

  function automatic logic [31:0] crt_widen(input logic [CNT_W-1:0] v);
    crt_widen = 32'(v);
  endfunction

  // Both pins go through the same sampler
  assign sample_tick = (s_r.phase == crt_pkg::PH_SAMPLE);

  crt_edge u_count_edge (
    .clk    (clk),
    .reset  (reset),
    .ce     (ce),
    .sample (sample_tick),
    .pin    (count_pin),
    .fall   (cnt_fall),
    .level  ()
  );

  crt_edge u_trig_edge (
    .clk    (clk),
    .reset  (reset),
    .ce     (ce),
    .sample (sample_tick),
    .pin    (trigger_pin),
    .fall   (trig_fall),
    .level  (trig_level)
  );

  always_comb begin
    logic update_tick;
    logic state_tick;
    logic baud;
    logic updown;
    logic step;
    logic trig_ev;
    logic roll;
    logic ev_of;
    logic ev_ex;
    logic setup;
    logic acc;
    logic wr;
    logic rd_status;
    logic clk_out_mode;
    update_tick  = 1'b0;
    state_tick   = 1'b0;
    baud         = 1'b0;
    updown       = 1'b0;
    step         = 1'b0;
    trig_ev      = 1'b0;
    roll         = 1'b0;
    ev_of        = 1'b0;
    ev_ex        = 1'b0;
    setup        = 1'b0;
    acc          = 1'b0;
    wr           = 1'b0;
    rd_status    = 1'b0;
    clk_out_mode = 1'b0;
    s_nxt        = s_r;

    // Machine cycle phase, twelve clocks per cycle
    if (s_r.phase == crt_pkg::PH_LAST) begin
      s_nxt.phase = 4'h0;
    end else begin
      s_nxt.phase = s_r.phase + 4'h1;
    end
    update_tick = (s_r.phase == crt_pkg::PH_UPDATE);
    state_tick  = s_r.phase[0];

    // Edges seen at the sample phase act at the next update phase
    if (update_tick) begin
      s_nxt.pend_cnt  = 1'b0;
      s_nxt.pend_trig = 1'b0;
    end
    if (cnt_fall) begin
      s_nxt.pend_cnt = 1'b1;
    end
    if (trig_fall) begin
      s_nxt.pend_trig = 1'b1;
    end

    // APB register writes
    setup = apb_req.psel & ~apb_req.penable;
    acc   = apb_req.psel & apb_req.penable & s_r.pready;
    wr    = acc & apb_req.pwrite & ~s_r.pslverr;
    rd_status = acc & ~apb_req.pwrite & (apb_req.paddr == crt_pkg::OFS_STATUS);
    if (wr) begin
      unique case (apb_req.paddr)
        crt_pkg::OFS_CTRL: begin
          s_nxt.ctrl = crt_pkg::crt_ctrl_t'(apb_req.pwdata[7:0]);
        end
        crt_pkg::OFS_MODE: begin
          s_nxt.mode          = crt_pkg::MODE_RST;
          s_nxt.mode.clock_output_enable = apb_req.pwdata[1];
          s_nxt.mode.up_down_enable      = apb_req.pwdata[0];
        end
        crt_pkg::OFS_CAPT: begin
          s_nxt.cap = apb_req.pwdata[CNT_W-1:0];
        end
        crt_pkg::OFS_MASK: begin
          s_nxt.irq_mask = apb_req.pwdata[1:0];
        end
        default: begin
        end
      endcase
    end

    // Mode decode
    baud   = s_r.ctrl.transmit_clock_select | s_r.ctrl.receive_clock_select;
    updown = ~baud & ~s_r.ctrl.capture_reload_select & s_r.mode.up_down_enable;
    clk_out_mode = s_r.mode.clock_output_enable & ~s_r.ctrl.count_source_select;

    // Counting step
    if (baud & ~s_r.ctrl.count_source_select) begin
      step = state_tick;
    end else if (s_r.ctrl.count_source_select) begin
      step = update_tick & s_r.pend_cnt;
    end else begin
      step = update_tick;
    end
    step    = step & s_r.ctrl.run_bit;
    trig_ev = update_tick & s_r.pend_trig & s_r.ctrl.external_trigger_enable;

    if (step) begin
      if (updown & ~trig_level) begin
        if (s_r.cnt == s_r.cap) begin
          s_nxt.cnt = ALL_ONES;
          roll      = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end else if (s_r.cnt == ALL_ONES) begin
        roll = 1'b1;
        if (s_r.ctrl.capture_reload_select & ~baud) begin
          s_nxt.cnt = '0;
        end else begin
          s_nxt.cnt = s_r.cap;
        end
      end else begin
        s_nxt.cnt = s_r.cnt + 1'b1;
      end
    end

    // Trigger edge outside up/down counting
    if (trig_ev & ~updown) begin
      ev_ex = 1'b1;
      s_nxt.ctrl.external_flag = 1'b1;
      if (~baud & s_r.ctrl.capture_reload_select) begin
        s_nxt.cap = s_r.cnt;
      end else if (~baud) begin
        s_nxt.cnt = s_r.cap;
      end
    end

    // Rollover effects; hardware set wins over a software clear
    if (roll) begin
      if (clk_out_mode) begin
        s_nxt.clock_out = ~s_r.clock_out;
      end
      if (~baud & ~clk_out_mode) begin
        ev_of = 1'b1;
        s_nxt.ctrl.overflow_flag = 1'b1;
      end
      if (updown) begin
        s_nxt.ctrl.external_flag = ~s_r.ctrl.external_flag;
      end
    end

    // Software count write takes precedence over the step
    if (wr && apb_req.paddr == crt_pkg::OFS_COUNT) begin
      s_nxt.cnt = apb_req.pwdata[CNT_W-1:0];
    end

    // Sticky status, cleared by reading it, new events win
    if (rd_status) begin
      s_nxt.irq_status = 2'h0;
    end
    s_nxt.irq_status[crt_pkg::ST_OVERFLOW] = s_nxt.irq_status[crt_pkg::ST_OVERFLOW] | ev_of;
    s_nxt.irq_status[crt_pkg::ST_EXTERNAL] = s_nxt.irq_status[crt_pkg::ST_EXTERNAL] | ev_ex;

    // APB answer: ready one cycle after setup
    if (setup) begin
      s_nxt.pready  = 1'b1;
      s_nxt.pslverr = ~crt_mapped(apb_req.paddr);
      unique case (apb_req.paddr)
        crt_pkg::OFS_CTRL:   s_nxt.prdata = 32'(s_r.ctrl);
        crt_pkg::OFS_MODE:   s_nxt.prdata = 32'(s_r.mode);
        crt_pkg::OFS_COUNT:  s_nxt.prdata = crt_widen(s_r.cnt);
        crt_pkg::OFS_CAPT:   s_nxt.prdata = crt_widen(s_r.cap);
        crt_pkg::OFS_STATUS: s_nxt.prdata = 32'(s_r.irq_status);
        crt_pkg::OFS_MASK:   s_nxt.prdata = 32'(s_r.irq_mask);
        default:             s_nxt.prdata = 32'h0000_0000;
      endcase
    end else if (acc) begin
      s_nxt.pready  = 1'b0;
      s_nxt.pslverr = 1'b0;
    end

    // Interrupt outputs
    s_nxt.timer_irq = s_nxt.ctrl.overflow_flag |
                      (s_nxt.ctrl.external_flag & ~(s_nxt.mode.up_down_enable &
                       ~s_nxt.ctrl.capture_reload_select &
                       ~(s_nxt.ctrl.transmit_clock_select | s_nxt.ctrl.receive_clock_select)));
    s_nxt.irq = |(s_nxt.irq_status & s_nxt.irq_mask);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r      <= '0;
      s_r.ctrl <= crt_pkg::CTRL_RST;
      s_r.mode <= crt_pkg::MODE_RST;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign prdata    = s_r.prdata;
  assign pready    = s_r.pready;
  assign pslverr   = s_r.pslverr;
  assign clock_out = s_r.clock_out;
  assign timer_irq = s_r.timer_irq;
  assign irq       = s_r.irq;

endmodule

// ==== shared/crt_pkg.sv ====
// Shared constants and types for the capture/reload timer
package crt_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_MODE   = 8'h04;
  localparam logic [7:0] OFS_COUNT  = 8'h08;
  localparam logic [7:0] OFS_CAPT   = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_MASK   = 8'h14;

  // Field positions in the status and mask registers
  localparam int ST_OVERFLOW = 0;
  localparam int ST_EXTERNAL = 1;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;

  // Counter width as built
  localparam int CNT_W_DEF = 16;

  // Oscillator periods per machine cycle and the phases used inside it
  localparam int          OSC_PER_MACHINE = 12;
  localparam logic [3:0]  PH_LAST   = 4'(OSC_PER_MACHINE - 1);
  localparam logic [3:0]  PH_UPDATE = 4'h4;
  localparam logic [3:0]  PH_SAMPLE = 4'h9;

  // Control register, bit 7 down to bit 0
  typedef struct packed {
    logic overflow_flag;
    logic external_flag;
    logic receive_clock_select;
    logic transmit_clock_select;
    logic external_trigger_enable;
    logic run_bit;
    logic count_source_select;
    logic capture_reload_select;
  } crt_ctrl_t;

  // Mode register, bit 7 down to bit 0
  typedef struct packed {
    logic [5:0] reserved;
    logic       clock_output_enable;
    logic       up_down_enable;
  } crt_mode_t;

  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } crt_apb_req_t;

  // Pin sampler state
  typedef struct packed {
    logic cur;
    logic fall;
  } crt_edge_st_t;

endpackage

// ==== logic/crt_edge.sv ====
// Once-per-machine-cycle pin sampler with falling edge detect
`timescale 1ns/1ps
module crt_edge (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic ce,
  // Sampling
  input  wire logic sample,
  input  wire logic pin,
  // Results
  output logic      fall,
  output logic      level
);

  crt_pkg::crt_edge_st_t s_r;
  crt_pkg::crt_edge_st_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.fall = 1'b0;
    if (sample) begin
      // High in one sample, low in the next
      s_nxt.fall = s_r.cur & ~pin;
      s_nxt.cur  = pin;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign fall  = s_r.fall;
  assign level = s_r.cur;

endmodule

// ==== tb/crt_properties.sv ====
// Port-level assertions for the capture/reload timer
`timescale 1ns/1ps
module crt_properties #(
  parameter int CNT_W = crt_pkg::CNT_W_DEF
) (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  reset,
  input wire logic                  ce,
  // APB
  input wire crt_pkg::crt_apb_req_t apb_req,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // Pins and requests
  input wire logic                  count_pin,
  input wire logic                  trigger_pin,
  input wire logic                  clock_out,
  input wire logic                  timer_irq,
  input wire logic                  irq
);
  logic wr_done;
  logic mapped;
  assign wr_done = apb_req.psel & apb_req.penable & apb_req.pwrite & pready;
  assign mapped  = (apb_req.paddr <= 8'h14) && (apb_req.paddr[1:0] == 2'h0);

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_setup;
    apb_req.psel && !apb_req.penable && ce;
  endsequence
  sequence s_access;
    apb_req.psel && apb_req.penable;
  endsequence

  a_ready_next: assert property (s_setup |=> pready)
    else $error("no answer after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_access: assert property (pready |-> s_access)
    else $error("ready outside an access");
  a_err_decode: assert property (pready |-> pslverr == !mapped)
    else $error("error flag does not match decode");
  a_err_zero: assert property (pslverr && !apb_req.pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_rdata_hold: assert property (!pready && !(apb_req.psel && !apb_req.penable) |=> $stable(prdata))
    else $error("read data moved between transfers");
  a_flag_sticky: assert property (
    $fell(timer_irq) |-> $past(wr_done, 1) || $past(wr_done, 2) || $past(wr_done, 3))
    else $error("timer request dropped without software");
  a_clkout_pace: assert property ($changed(clock_out) |=> $stable(clock_out))
    else $error("clock output toggled faster than two cycles");
endmodule

bind crt_timer crt_properties #(.CNT_W(CNT_W)) u_props (.clk(clk), .reset(reset), .ce(ce), .apb_req(apb_req),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .count_pin(count_pin), .trigger_pin(trigger_pin),
  .clock_out(clock_out), .timer_irq(timer_irq), .irq(irq));

// ==== tb/crt_pins.sv ====
// External source for the count and trigger pins
`timescale 1ns/1ps
module crt_pins (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Requested levels
  input  wire logic want_cnt,
  input  wire logic want_trg,
  // Pins
  output logic      count_pin,
  output logic      trigger_pin
);
  logic [3:0] hold_c;
  logic [3:0] hold_t;

  // A new level is only applied once the old one stood a full machine cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {count_pin, trigger_pin} <= 2'h3;
      {hold_c, hold_t} <= 8'h00;
    end else begin
      hold_c <= (hold_c == 4'hC) ? hold_c : hold_c + 4'h1;
      hold_t <= (hold_t == 4'hC) ? hold_t : hold_t + 4'h1;
      if (hold_c == 4'hC && want_cnt != count_pin) begin
        count_pin <= want_cnt;
        hold_c <= 4'h0;
      end
      if (hold_t == 4'hC && want_trg != trigger_pin) begin
        trigger_pin <= want_trg;
        hold_t <= 4'h0;
      end
    end
  end
endmodule

// ==== tb/capture_reload_timer_bench.sv ====
// Self-checking bench for the capture/reload timer
`timescale 1ns/1ps
module capture_reload_timer_bench;
  localparam logic [7:0] CT = crt_pkg::OFS_CTRL;
  localparam logic [7:0] MD = crt_pkg::OFS_MODE;
  localparam logic [7:0] CN = crt_pkg::OFS_COUNT;
  localparam logic [7:0] CP = crt_pkg::OFS_CAPT;
  localparam logic [7:0] ST = crt_pkg::OFS_STATUS;
  localparam logic [7:0] MK = crt_pkg::OFS_MASK;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic s;} crt_row_t;

  logic                  clk = 1'b0;
  logic                  reset = 1'b1;
  logic                  wc = 1'b1;
  logic                  wt = 1'b1;
  logic                  en = 1'b1;
  crt_pkg::crt_apb_req_t rq = '0;
  logic [31:0]           prdata;
  logic [31:0]           q;
  logic [31:0]           a0;
  logic                  se;
  logic                  pready;
  logic                  pslverr;
  logic                  cp_pin;
  logic                  tp_pin;
  logic                  clock_out;
  logic                  timer_irq;
  logic                  irq;
  int                    err_total = 0;
  int                    checks_done = 0;
  crt_row_t              rows [7] = '{
    '{MD, 32'h3, 32'h3, 1'b0}, '{MD, 32'hFF, 32'h3, 1'b0}, '{CP, 32'hFFF0, 32'hFFF0, 1'b0},
    '{CN, 32'h1234, 32'h1234, 1'b0}, '{MK, 32'h3, 32'h3, 1'b0}, '{CT, 32'h8, 32'h8, 1'b0},
    '{8'h18, 32'h55, 32'h0, 1'b1}};

  always #10 clk = ~clk;

  crt_timer uut (.clk(clk), .reset(reset), .ce(en), .apb_req(rq), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_pin(cp_pin), .trigger_pin(tp_pin), .clock_out(clock_out),
    .timer_irq(timer_irq), .irq(irq));
  crt_pins pins (.clk(clk), .reset(reset), .want_cnt(wc), .want_trg(wt), .count_pin(cp_pin),
    .trigger_pin(tp_pin));

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
    int n = 0;
    @(posedge clk);
    rq <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    rq.penable <= 1'b1;
    // Wait for the answer however long it takes; the watchdog ends a hang
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    chk("waits", 32'h1, 32'(n));
    rq.psel <= 1'b0;
    rq.penable <= 1'b0;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rc(logic [7:0] a, logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q);
  endtask

  initial begin
    cyc(4);
    reset <= 1'b0;
    rc(CT, 32'h0);
    rc(MD, 32'h0);
    chk("tirq", 32'h0, 32'(timer_irq));
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk("werr", 32'(rows[i].s), 32'(se));
      cyc(30);
      rc(rows[i].a, rows[i].e);
      chk("rerr", 32'(rows[i].s), 32'(se));
    end
    wr(MD, 32'h0);
    wr(CP, 32'h5A5A);
    wr(CN, 32'h1);
    wt <= 1'b0;
    cyc(50);
    rc(CN, 32'h5A5A);
    rc(CT, 32'h48);
    chk("tirq", 32'h1, 32'(timer_irq));
    chk("irq", 32'h1, 32'(irq));
    rc(ST, 32'h2);
    cyc(3);
    chk("irq", 32'h0, 32'(irq));
    wt <= 1'b1;
    cyc(30);
    wr(CT, 32'h9);
    wr(CN, 32'h1234);
    wt <= 1'b0;
    cyc(50);
    rc(CP, 32'h1234);
    rc(CT, 32'h49);
    wt <= 1'b1;
    cyc(30);
    wr(MK, 32'h0);
    xfer(1'b0, ST, 32'h0);
    wr(CT, 32'h0);
    wr(CP, 32'hFFF0);
    wr(CN, 32'h0);
    wr(CT, 32'h4);
    xfer(1'b0, CN, 32'h0);
    a0 = q;
    cyc(117);
    xfer(1'b0, CN, 32'h0);
    chk("rate", 32'hA, q - a0);
    // Sixty frozen clocks out of one hundred twenty leave five machine cycles
    a0 = q;
    en <= 1'b0;
    cyc(60);
    en <= 1'b1;
    cyc(57);
    xfer(1'b0, CN, 32'h0);
    chk("freeze", 32'h5, q - a0);
    wr(CN, 32'hFFFE);
    cyc(28);
    xfer(1'b0, CN, 32'h0);
    chk("reload", 32'hFFF0, q & 32'hFFFE);
    chk("irq", 32'h0, 32'(irq));
    chk("tirq", 32'h1, 32'(timer_irq));
    wr(CT, 32'h80);
    cyc(30);
    chk("tirq", 32'h1, 32'(timer_irq));
    wr(MK, 32'h1);
    cyc(3);
    chk("irq", 32'h1, 32'(irq));
    rc(ST, 32'h1);
    cyc(3);
    chk("irq", 32'h0, 32'(irq));
    wr(CT, 32'h0);
    cyc(3);
    chk("tirq", 32'h0, 32'(timer_irq));
    wr(CT, 32'h6);
    wr(CN, 32'h0);
    repeat (3) begin
      wc <= 1'b0;
      cyc(30);
      wc <= 1'b1;
      cyc(30);
    end
    cyc(30);
    rc(CN, 32'h3);
    wr(CT, 32'h0);
    wr(MD, 32'h1);
    wt <= 1'b0;
    cyc(30);
    wr(CP, 32'h100);
    wr(CN, 32'h102);
    wr(CT, 32'h4);
    cyc(60);
    rc(CT, 32'hC4);
    wr(CT, 32'h44);
    cyc(5);
    chk("tirq", 32'h0, 32'(timer_irq));
    wr(CT, 32'h40);
    wt <= 1'b1;
    cyc(30);
    wr(CN, 32'hFFFD);
    wr(CT, 32'h44);
    cyc(60);
    rc(CT, 32'h84);
    wr(CT, 32'h0);
    wr(MD, 32'h2);
    wr(CN, 32'hFFF0);
    wr(CT, 32'h14);
    xfer(1'b0, CN, 32'h0);
    a0 = q;
    cyc(21);
    xfer(1'b0, CN, 32'h0);
    chk("baud", 32'hC, q - a0);
    cyc(100);
    rc(CT, 32'h14);
    chk("clkout", 32'h1, 32'(clock_out));
    // Baud rollover alone, clock output off
    wr(MD, 32'h0);
    wr(CN, 32'hFFFE);
    cyc(30);
    rc(CT, 32'h14);
    chk("clkout", 32'h1, 32'(clock_out));
    // Reset in mid-run
    wr(MD, 32'h1);
    reset <= 1'b1;
    cyc(4);
    reset <= 1'b0;
    rc(MD, 32'h0);
    rc(CT, 32'h0);
    summarize();
  end

  initial begin
    cyc(20000);
    err_total++;
    summarize();
  end
endmodule
